/* srg_pkg.sv */
// shared constants and types for the start/restart generator
`default_nettype none
package srg_pkg;
    // register port widths
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;

    // register indexes
    localparam logic [3:0] REG_CTRL0 = 4'h0;
    localparam logic [3:0] REG_TXB = 4'h1;
    localparam logic [3:0] REG_CNT = 4'h2;
    localparam logic [3:0] REG_ADB0 = 4'h3;
    localparam logic [3:0] REG_ADB1 = 4'h4;
    localparam logic [3:0] REG_STAT = 4'h5;
    localparam logic [3:0] REG_SHL = 4'h6;
    localparam logic [3:0] REG_SHH = 4'h7;

    // control_register_0 bit positions
    localparam int CTRL_START = 0;
    localparam int CTRL_RESTART_ENABLE = 1;
    localparam int CTRL_ABD = 2;
    localparam int CTRL_ABORT = 3;

    // status bit positions
    localparam int STAT_BUS_FREE_FLAG = 0;
    localparam int STAT_SDET = 1;
    localparam int STAT_RDET = 2;
    localparam int STAT_BCL = 3;

    // timing in ticks of the selected i2c clock source
    localparam int HALF_TICKS_DEF = 4;
    localparam int BUS_FREE_TICKS_DEF = 8;
    localparam int TMR_W = 16;

    // reset values
    localparam logic [7:0] BYTE_RST = 8'h00;
    localparam logic [TMR_W-1:0] TMR_RST = 16'h0000;

    typedef struct packed {
        logic abort;
        logic addressBufferDisable;
        logic restartEnable;
        logic start;
    } srg_ctrl_t;

    typedef struct packed {
        logic scl;
        logic sda;
    } srg_lines_t;

    typedef struct packed {
        logic busCollision;
        logic restartDetected;
        logic startDetected;
    } srg_flags_t;

    typedef enum logic [6:0] {
        S_IDLE = 7'h01,
        S_WAIT = 7'h02,
        S_START = 7'h04,
        S_HELD = 7'h08,
        S_RSDA = 7'h10,
        S_RSCL = 7'h20,
        S_RLOW = 7'h40
    } srg_state_t;
endpackage
`default_nettype wire

/* srg_tick_sync.sv */
// carries the selected i2c source clock into the device domain as ticks
`timescale 1ns/100ps
`default_nettype none
module srg_tick_sync (
    input wire logic clk,
    input wire logic rst,
    input wire logic linkClk,
    input wire logic linkRst,
    output logic tick
);
    logic linkTog;
    logic next_linkTog;
    logic [2:0] togSync;

    // toggle per source edge; held 15 ns so the 8 ns side sees it
    always_comb begin
        next_linkTog = ~linkTog;
    end

    always_ff @(posedge linkClk) begin
        if (linkRst) begin
            linkTog <= 1'b0;
        end else begin
            linkTog <= next_linkTog;
        end
    end

    // two flops, then a third for the edge compare
    always_ff @(posedge clk) begin
        if (rst) begin
            togSync <= 3'h0;
        end else begin
            togSync <= {togSync[1:0], linkTog};
        end
    end

    assign tick = togSync[2] ^ togSync[1]; // first stage never read here
endmodule
`default_nettype wire

/* srg_start_gen.sv */
// i2c master start and repeated start generator with register port
//
// Design decisions made here: the plain strobed port and the register offsets.
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// - A start is requested by the start bit with address_buffer_disable clear, or by a transmit_buffer write when address_buffer_disable is set.
// - After a start request the master leaves the bus alone until bus_free_flag reads one.
// - The start is SDA pulled low while SCL is high, and it sets start_detected_flag.
// - One scl_period after SDA falls the master drives SCL low, ending the start.
// - A repeated start runs when the start bit is set while stalled with restart_enable one and byte_count zero.
// - A repeated start first releases SDA for half an scl_period, then releases SCL for another half.
// - SDA seen low after both lines are released sets bus_collision_flag and returns to idle.
// - SDA seen high at that check is pulled low and held for one scl_period.
// - Then SCL is driven low and the address_buffer_pair is loaded into the shift register.
// - restart_detected_flag is set as soon as a restart is seen on the lines.
module srg_start_gen #(
    parameter int HALF_TICKS = srg_pkg::HALF_TICKS_DEF,
    parameter int BUS_FREE_TICKS = srg_pkg::BUS_FREE_TICKS_DEF
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic linkClk,
    input wire logic linkRst,
    input wire logic [srg_pkg::ADDR_W-1:0] regAddr,
    input wire logic [srg_pkg::DATA_W-1:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    output logic [srg_pkg::DATA_W-1:0] regRdData,
    input wire logic sclIn,
    output logic sclOut,
    output logic sclOe,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOe
);
    localparam logic [srg_pkg::TMR_W-1:0] HALF_END =
        srg_pkg::TMR_W'(HALF_TICKS - 1);
    localparam logic [srg_pkg::TMR_W-1:0] FULL_END =
        srg_pkg::TMR_W'(2 * HALF_TICKS - 1);
    localparam logic [7:0] FREE_END = 8'(BUS_FREE_TICKS);
    localparam logic [7:0] BYTE_ZERO = 8'h00;

    logic tick;
    logic [1:0] sclSync;
    logic [1:0] sdaSync;
    srg_pkg::srg_lines_t lines;
    srg_pkg::srg_lines_t linesPrev;
    logic pinStart;
    logic pinStop;
    logic busy;
    logic next_busy;
    logic [7:0] freeCnt;
    logic [7:0] next_freeCnt;
    logic busFree;

    srg_pkg::srg_state_t state;
    srg_pkg::srg_state_t next_state;
    logic [srg_pkg::TMR_W-1:0] tmr;
    logic [srg_pkg::TMR_W-1:0] next_tmr;
    logic next_sdaOe;
    logic next_sclOe;
    logic clrStart;
    logic loadShift;
    logic setBcl;

    srg_pkg::srg_ctrl_t ctrl;
    srg_pkg::srg_ctrl_t next_ctrl;
    srg_pkg::srg_flags_t flags;
    srg_pkg::srg_flags_t next_flags;
    logic [7:0] txb;
    logic [7:0] next_txb;
    logic [7:0] byteCount;
    logic [7:0] next_byteCount;
    logic [7:0] adb0;
    logic [7:0] next_adb0;
    logic [7:0] adb1;
    logic [7:0] next_adb1;
    logic [15:0] shiftReg;
    logic [15:0] next_shiftReg;
    logic [7:0] next_rdData;
    logic abortReq;

    // source clock ticks pace every delay below
    srg_tick_sync u_tick (
        .clk(clk),
        .rst(rst),
        .linkClk(linkClk),
        .linkRst(linkRst),
        .tick(tick)
    );

    // open drain: only the enables move, the level is always low
    assign sclOut = 1'b0;
    assign sdaOut = 1'b0;

    // pin synchronisers, then one more stage for edge compares
    always_ff @(posedge clk) begin
        if (rst) begin
            sclSync <= 2'h3;
            sdaSync <= 2'h3;
            linesPrev <= 2'h3;
        end else begin
            sclSync <= {sclSync[0], sclIn};
            sdaSync <= {sdaSync[0], sdaIn};
            linesPrev <= lines;
        end
    end

    // line watcher: start/stop seen on the wires, bus free timing
    always_comb begin
        lines.scl = sclSync[1];
        lines.sda = sdaSync[1];
        pinStart = linesPrev.scl & lines.scl & linesPrev.sda & ~lines.sda;
        pinStop = linesPrev.scl & lines.scl & ~linesPrev.sda & lines.sda;
        busFree = (freeCnt == FREE_END);
        next_busy = busy;
        if (pinStart) begin
            next_busy = 1'b1;
        end else if (pinStop) begin
            next_busy = 1'b0;
        end
        next_freeCnt = freeCnt;
        if (!lines.scl || !lines.sda || busy) begin
            next_freeCnt = 8'h00;
        end else if (tick && !busFree) begin
            next_freeCnt = freeCnt + 8'h01;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            busy <= 1'b0;
            freeCnt <= 8'h00;
        end else begin
            busy <= next_busy;
            freeCnt <= next_freeCnt;
        end
    end

    // sequencer: timer advances only on source ticks
    always_comb begin
        next_state = state;
        next_tmr = tmr;
        next_sdaOe = sdaOe;
        next_sclOe = sclOe;
        clrStart = 1'b0;
        loadShift = 1'b0;
        setBcl = 1'b0;
        case (state)
            srg_pkg::S_IDLE: begin
                next_sdaOe = 1'b0;
                next_sclOe = 1'b0;
                if (ctrl.start) begin
                    next_state = srg_pkg::S_WAIT;
                end
            end
            srg_pkg::S_WAIT: begin
                // hands off until the bus has been free long enough
                if (busFree) begin
                    next_state = srg_pkg::S_START;
                    next_sdaOe = 1'b1; // sda low under high scl
                    next_tmr = srg_pkg::TMR_RST;
                end
            end
            srg_pkg::S_START: begin
                if (tick) begin
                    next_tmr = tmr + 16'h0001;
                    if (tmr == FULL_END) begin
                        // a full period later scl goes low
                        next_state = srg_pkg::S_HELD;
                        next_sclOe = 1'b1;
                        clrStart = 1'b1;
                        loadShift = 1'b1;
                    end
                end
            end
            srg_pkg::S_HELD: begin
                if (abortReq) begin
                    next_state = srg_pkg::S_IDLE;
                    next_sdaOe = 1'b0;
                    next_sclOe = 1'b0;
                end else if (ctrl.start && ctrl.restartEnable &&
                        byteCount == BYTE_ZERO) begin
                    // stalled in restart stretch, so restart
                    next_state = srg_pkg::S_RSDA;
                    next_sdaOe = 1'b0; // release sda first
                    next_tmr = srg_pkg::TMR_RST;
                end
            end
            srg_pkg::S_RSDA: begin
                if (tick) begin
                    next_tmr = tmr + 16'h0001;
                    if (tmr == HALF_END) begin
                        next_state = srg_pkg::S_RSCL;
                        next_sclOe = 1'b0; // then let scl float
                        next_tmr = srg_pkg::TMR_RST;
                    end
                end
            end
            srg_pkg::S_RSCL: begin
                if (tick) begin
                    next_tmr = tmr + 16'h0001;
                    if (tmr == HALF_END) begin
                        next_tmr = srg_pkg::TMR_RST;
                        if (!lines.sda) begin
                            // someone else holds sda low
                            next_state = srg_pkg::S_IDLE;
                            setBcl = 1'b1;
                            clrStart = 1'b1;
                        end else begin
                            next_state = srg_pkg::S_RLOW;
                            next_sdaOe = 1'b1; // form the start
                        end
                    end
                end
            end
            srg_pkg::S_RLOW: begin
                if (tick) begin
                    next_tmr = tmr + 16'h0001;
                    if (tmr == FULL_END) begin
                        // scl low and address pair into shifter
                        next_state = srg_pkg::S_HELD;
                        next_sclOe = 1'b1;
                        clrStart = 1'b1;
                        loadShift = 1'b1;
                    end
                end
            end
            default: begin
                next_state = srg_pkg::S_IDLE;
                next_sdaOe = 1'b0;
                next_sclOe = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state <= srg_pkg::S_IDLE;
            tmr <= srg_pkg::TMR_RST;
            sdaOe <= 1'b0;
            sclOe <= 1'b0;
        end else begin
            state <= next_state;
            tmr <= next_tmr;
            sdaOe <= next_sdaOe;
            sclOe <= next_sclOe;
        end
    end

    // register file; hardware sets win over software clears
    always_comb begin
        next_ctrl = ctrl;
        next_txb = txb;
        next_byteCount = byteCount;
        next_adb0 = adb0;
        next_adb1 = adb1;
        next_flags = flags;
        next_shiftReg = shiftReg;
        next_rdData = 8'h00;
        abortReq = 1'b0;
        if (regWr) begin
            case (regAddr)
                srg_pkg::REG_CTRL0: begin
                    next_ctrl.restartEnable = regWrData[srg_pkg::CTRL_RESTART_ENABLE];
                    next_ctrl.addressBufferDisable =
                        regWrData[srg_pkg::CTRL_ABD];
                    abortReq = regWrData[srg_pkg::CTRL_ABORT];
                    // the mode written with the bit decides its meaning
                    if (regWrData[srg_pkg::CTRL_START] &&
                            (!regWrData[srg_pkg::CTRL_ABD] ||
                            state == srg_pkg::S_HELD)) begin
                        next_ctrl.start = 1'b1;
                    end
                end
                srg_pkg::REG_TXB: begin
                    next_txb = regWrData;
                    if (ctrl.addressBufferDisable &&
                            state == srg_pkg::S_IDLE) begin
                        next_ctrl.start = 1'b1; // buffer write path
                    end
                end
                srg_pkg::REG_CNT: next_byteCount = regWrData;
                srg_pkg::REG_ADB0: next_adb0 = regWrData;
                srg_pkg::REG_ADB1: next_adb1 = regWrData;
                srg_pkg::REG_STAT: begin
                    // write one to clear
                    if (regWrData[srg_pkg::STAT_SDET]) begin
                        next_flags.startDetected = 1'b0;
                    end
                    if (regWrData[srg_pkg::STAT_RDET]) begin
                        next_flags.restartDetected = 1'b0;
                    end
                    if (regWrData[srg_pkg::STAT_BCL]) begin
                        next_flags.busCollision = 1'b0;
                    end
                end
                default: begin
                end
            endcase
        end
        next_ctrl.abort = 1'b0; // pulse only, never stored
        if (clrStart || abortReq) begin
            next_ctrl.start = 1'b0;
        end
        // start and restart flags come from the wires, so both own and foreign starts count
        if (pinStart && !busy) begin
            next_flags.startDetected = 1'b1;
        end
        if (pinStart && busy) begin
            next_flags.restartDetected = 1'b1;
        end
        if (setBcl) begin
            next_flags.busCollision = 1'b1;
        end
        if (loadShift) begin
            // pair loaded on restart; plain start takes txb when disabled
            if (ctrl.addressBufferDisable && state == srg_pkg::S_START) begin
                next_shiftReg = {BYTE_ZERO, txb};
            end else begin
                next_shiftReg = {adb1, adb0};
            end
        end
        if (regRd) begin
            case (regAddr)
                srg_pkg::REG_CTRL0: next_rdData = {4'h0, ctrl};
                srg_pkg::REG_TXB: next_rdData = txb;
                srg_pkg::REG_CNT: next_rdData = byteCount;
                srg_pkg::REG_ADB0: next_rdData = adb0;
                srg_pkg::REG_ADB1: next_rdData = adb1;
                srg_pkg::REG_STAT: next_rdData = {4'h0, flags, busFree};
                srg_pkg::REG_SHL: next_rdData = shiftReg[7:0];
                srg_pkg::REG_SHH: next_rdData = shiftReg[15:8];
                default: next_rdData = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            ctrl <= 4'h0;
            txb <= srg_pkg::BYTE_RST;
            byteCount <= srg_pkg::BYTE_RST;
            adb0 <= srg_pkg::BYTE_RST;
            adb1 <= srg_pkg::BYTE_RST;
            flags <= 3'h0;
            shiftReg <= 16'h0000;
            regRdData <= 8'h00;
        end else begin
            ctrl <= next_ctrl;
            txb <= next_txb;
            byteCount <= next_byteCount;
            adb0 <= next_adb0;
            adb1 <= next_adb1;
            flags <= next_flags;
            shiftReg <= next_shiftReg;
            regRdData <= next_rdData;
        end
    end

    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    chk_free_wait: assert property (
        (state == srg_pkg::S_WAIT && !busFree) |=> !sdaOe && !sclOe)
        else $error("bus driven before it was free");
    chk_start_shape: assert property (
        state == srg_pkg::S_START |-> sdaOe && !sclOe)
        else $error("start not sda low under released scl");
    chk_start_flag: assert property (
        (pinStart && !busy) |=> flags.startDetected)
        else $error("start flag not set");
    chk_start_len: assert property (
        ($past(state) == srg_pkg::S_START && state == srg_pkg::S_HELD)
        |-> $past(tick) && $past(tmr) == FULL_END && sclOe)
        else $error("scl low not one period after start");
    chk_rs_entry: assert property (
        (state == srg_pkg::S_HELD && ctrl.start && ctrl.restartEnable &&
        byteCount == BYTE_ZERO && !abortReq)
        |=> state == srg_pkg::S_RSDA && !sdaOe && sclOe)
        else $error("restart not entered");
    chk_rs_half: assert property (
        ($past(state) == srg_pkg::S_RSDA && state == srg_pkg::S_RSCL)
        |-> $past(tmr) == HALF_END && !sclOe && !sdaOe)
        else $error("restart half period wrong");
    chk_rs_collide: assert property (
        (state == srg_pkg::S_RSCL && tick && tmr == HALF_END && !lines.sda)
        |=> state == srg_pkg::S_IDLE ##1 flags.busCollision && !sdaOe)
        else $error("collision not flagged");
    chk_rs_low: assert property (
        state == srg_pkg::S_RLOW |-> sdaOe && !sclOe)
        else $error("restart start not held low");
    chk_rs_load: assert property (
        ($past(state) == srg_pkg::S_RLOW && state == srg_pkg::S_HELD)
        |=> shiftReg == $past({adb1, adb0}, 2))
        else $error("address pair not loaded");
    chk_rs_flag: assert property (
        (pinStart && busy) |=> flags.restartDetected)
        else $error("restart flag not set");
    chk_tick_pace: assert property (
        (!tick && state != srg_pkg::S_IDLE && state != srg_pkg::S_WAIT &&
        state != srg_pkg::S_HELD) |=> state == $past(state))
        else $error("sequence moved without a tick");

    cov_start: cover property (
        state == srg_pkg::S_START ##1 state == srg_pkg::S_HELD);
    cov_restart: cover property (
        state == srg_pkg::S_RLOW ##1 state == srg_pkg::S_HELD);
    cov_collide: cover property (
        state == srg_pkg::S_RSCL ##1 state == srg_pkg::S_IDLE);
endmodule
`default_nettype wire

/* srg_bus_model.sv */
// open-drain scl/sda bus with pull-ups and a slave that can hold either line
`timescale 1ns/100ps
`default_nettype none
module srg_bus_model (
    input wire logic sclOe,
    input wire logic sclOut,
    input wire logic sdaOe,
    input wire logic sdaOut,
    input wire logic holdScl,
    input wire logic holdSda,
    output logic sclWire,
    output logic sdaWire
);
    // wired-and: a released line floats to the pull-up, never the last value
    assign sclWire = (sclOe ? sclOut : 1'b1) & ~holdScl;
    assign sdaWire = (sdaOe ? sdaOut : 1'b1) & ~holdSda;
endmodule
`default_nettype wire

/* i2c_master_start_restart_gen_test.sv */
// register-level bench for the start and repeated start generator
`timescale 1ns/100ps
`default_nettype none
module i2c_master_start_restart_gen_test;
    logic clk = 1'b0;
    logic linkClk = 1'b0;
    logic rst = 1'b1;
    logic linkRst = 1'b1;
    logic [3:0] regAddr = 4'h0;
    logic [7:0] regWrData = 8'h00;
    logic regWr = 1'b0;
    logic regRd = 1'b0;
    logic [7:0] regRdData;
    logic sclOut, sclOe, sdaOut, sdaOe, sclWire, sdaWire;
    logic holdScl = 1'b0;
    logic holdSda = 1'b0;
    int num_errors = 0;
    int comparisons = 0;
    int cycles = 0;
    int n;

    always #4 clk = ~clk;
    always #7.5 linkClk = ~linkClk;

    // short half period keeps every start sequence to a few dozen cycles
    srg_start_gen #(.HALF_TICKS(2), .BUS_FREE_TICKS(2)) dut (
        .clk(clk), .rst(rst), .linkClk(linkClk), .linkRst(linkRst),
        .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
        .regRd(regRd), .regRdData(regRdData),
        .sclIn(sclWire), .sclOut(sclOut), .sclOe(sclOe),
        .sdaIn(sdaWire), .sdaOut(sdaOut), .sdaOe(sdaOe)
    );

    srg_bus_model slave (
        .sclOe(sclOe), .sclOut(sclOut), .sdaOe(sdaOe), .sdaOut(sdaOut),
        .holdScl(holdScl), .holdSda(holdSda),
        .sclWire(sclWire), .sdaWire(sdaWire)
    );

    task automatic complete_run();
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // a hang counts as a mismatch
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            num_errors = num_errors + 1;
            complete_run();
        end
    end

    task automatic check8(input logic [7:0] got, input logic [7:0] exp);
        comparisons = comparisons + 1;
        if (got !== exp) begin
            num_errors = num_errors + 1;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic checkRange(input int got, input int lo, input int hi);
        comparisons = comparisons + 1;
        if (got < lo || got > hi) begin
            num_errors = num_errors + 1;
            $display("Error at %0t: got %h expected %h..%h", $time, got,
                lo, hi);
        end
    endtask

    task automatic regWrite(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        regAddr <= a;
        regWrData <= d;
        regWr <= 1'b1;
        @(posedge clk);
        regWr <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic regCheck(input logic [3:0] a, input logic [7:0] exp);
        @(posedge clk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge clk);
        regRd <= 1'b0;
        #1;
        check8(regRdData, exp);
    endtask

    // cycles until the chosen enable reaches lvl, capped at lim
    task automatic waitOe(input logic sel, input logic lvl, input int lim,
        output int cnt);
        cnt = 0;
        do begin
            @(posedge clk);
            #1;
            cnt = cnt + 1;
        end while ((sel ? sdaOe : sclOe) !== lvl && cnt < lim);
    endtask

    task automatic idle(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask

    task automatic checkPins(input logic scl, input logic sda);
        check8({6'h00, sclOe, sdaOe}, {6'h00, scl, sda});
    endtask

    initial begin
        repeat (3) @(posedge linkClk);
        linkRst <= 1'b0;
    end

    initial begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        #1;
        // reset values, unmapped index reads zero
        checkPins(1'b0, 1'b0);
        regCheck(srg_pkg::REG_CTRL0, 8'h00);
        regWrite(4'hf, 8'hff);
        regCheck(4'hf, 8'h00);
        regWrite(srg_pkg::REG_ADB0, 8'ha5);
        regWrite(srg_pkg::REG_ADB1, 8'h3c);
        // slave stretches scl: start must wait for a free bus
        holdScl <= 1'b1;
        regWrite(srg_pkg::REG_CTRL0, 8'h01);
        idle(40);
        checkPins(1'b0, 1'b0);
        holdScl <= 1'b0;
        waitOe(1'b1, 1'b1, 60, n);
        checkRange(n, 1, 59);
        check8({7'h00, sclOe}, 8'h00);
        waitOe(1'b0, 1'b1, 40, n);
        checkRange(n, 6, 14);
        regCheck(srg_pkg::REG_STAT, 8'h01 << srg_pkg::STAT_SDET);
        regCheck(srg_pkg::REG_SHL, 8'ha5);
        regCheck(srg_pkg::REG_SHH, 8'h3c);
        regCheck(srg_pkg::REG_CTRL0, 8'h00);
        regWrite(srg_pkg::REG_STAT, 8'h0e);
        regCheck(srg_pkg::REG_STAT, 8'h00);
        // restart refused while byte_count is not zero
        regWrite(srg_pkg::REG_CNT, 8'h01);
        regWrite(srg_pkg::REG_CTRL0, 8'h03);
        idle(20);
        checkPins(1'b1, 1'b1);
        // start stays pending; restart_enable low keeps it refused
        regWrite(srg_pkg::REG_CTRL0, 8'h00);
        regWrite(srg_pkg::REG_CNT, 8'h00);
        idle(10);
        checkPins(1'b1, 1'b1);
        // clean repeated start from the stall
        regWrite(srg_pkg::REG_ADB0, 8'h11);
        regWrite(srg_pkg::REG_ADB1, 8'h22);
        regWrite(srg_pkg::REG_CTRL0, 8'h03);
        waitOe(1'b1, 1'b0, 12, n);
        checkRange(n, 1, 11);
        check8({7'h00, sclOe}, 8'h01);
        waitOe(1'b0, 1'b0, 20, n);
        checkRange(n, 2, 8);
        waitOe(1'b1, 1'b1, 20, n);
        checkRange(n, 2, 8);
        check8({7'h00, sclOe}, 8'h00);
        waitOe(1'b0, 1'b1, 30, n);
        checkRange(n, 5, 12);
        regCheck(srg_pkg::REG_STAT, 8'h01 << srg_pkg::STAT_RDET);
        regCheck(srg_pkg::REG_SHL, 8'h11);
        regCheck(srg_pkg::REG_SHH, 8'h22);
        regWrite(srg_pkg::REG_STAT, 8'h0e);
        // slave holds sda low: restart must end in a collision
        holdSda <= 1'b1;
        regWrite(srg_pkg::REG_CTRL0, 8'h03);
        waitOe(1'b0, 1'b0, 20, n);
        idle(20);
        checkPins(1'b0, 1'b0);
        regCheck(srg_pkg::REG_STAT, 8'h01 << srg_pkg::STAT_BCL);
        holdSda <= 1'b0;
        regWrite(srg_pkg::REG_STAT, 8'h0e);
        idle(30);
        // address_buffer_disable set: start bit ignored, buffer write starts
        regWrite(srg_pkg::REG_CTRL0, 8'h05);
        idle(20);
        checkPins(1'b0, 1'b0);
        regWrite(srg_pkg::REG_TXB, 8'h5a);
        waitOe(1'b1, 1'b1, 60, n);
        checkRange(n, 1, 59);
        waitOe(1'b0, 1'b1, 40, n);
        checkRange(n, 6, 14);
        regCheck(srg_pkg::REG_SHL, 8'h5a);
        regCheck(srg_pkg::REG_SHH, 8'h00);
        regWrite(srg_pkg::REG_CTRL0, 8'h0c);
        idle(10);
        checkPins(1'b0, 1'b0);
        regCheck(srg_pkg::REG_CTRL0, 8'h04);
        complete_run();
    end
endmodule
`default_nettype wire
